/* File: tb.sv */
// Self-checking testbench for the vector length configuration block.
`timescale 1ns/1ns
`default_nettype none
module tb
    import vlc_pkg::*;
;
    logic sys_clk = 0, rst = 1, issueValid = 0, destWrite, accepted;
    logic [31:0] instr = 0, src1Value, src2Value, destValue, cfgType, lenCsr;
    logic [31:0] rnd = 32'h0000_0050, ty, req;
    logic [4:0] destIndex;
    logic [63:0] expQ [$];
    int errorCnt = 0, cmpCount = 0;
    logic [31:0] word;
    logic [63:0] note;
    // Clock at 250 MHz.
    always #2 sys_clk = ~sys_clk;
    vlc_config dut_u (.sys_clk, .rst, .issueValid, .instr, .src1Value,
        .src2Value, .destWrite, .destIndex, .destValue, .accepted,
        .vector_config_type(cfgType), .vector_length_csr(lenCsr),
        .maskAgnostic(), .tailAgnostic());
    vlc_scalar_pipe pipe_u (.sys_clk, .instr, .destWrite, .destIndex,
        .destValue, .src1Value, .src2Value);
    // Xorshift step for the random stimulus.
    function automatic logic [31:0] nextRnd(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Expected type and length for a requested type and length.
    function automatic logic [63:0] expectOf(input logic [31:0] t,
        input logic [31:0] r);
        logic [31:0] mx;
        mx = (32'h10 >> t[4:3]) << t[1:0];
        if (t[2]) begin
            mx = (32'h10 >> t[4:3]) >> (4'h8 - t[2:0]);
        end
        if (t[31:8] != 0 || t[5] || t[2:0] == 3'h4 || mx == 0) begin
            return 64'h8000_0000_0000_0000;
        end
        return {t, (r < mx) ? r : mx};
    endfunction
    task check(input logic [63:0] seen, input logic [63:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Issues one word with operands in x2 and x3, noting any write-back.
    task issue(input logic [31:0] w, input logic [31:0] a,
        input logic [31:0] b, input logic [63:0] e);
        @(negedge sys_clk);
        pipe_u.regs[2] = a;
        pipe_u.regs[3] = b;
        instr = w;
        issueValid = 1;
        if (w[11:7] != 0) expQ.push_back(e);
    endtask
    task giveVerdict();
        $display("errors %0d compares %0d", errorCnt, cmpCount);
        if (errorCnt == 0 && cmpCount > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Each write-back is compared with the oldest note.
    // A write-back with no note left counts as a stray pulse.
    always @(negedge sys_clk) begin
        if (destWrite === 1'b1) begin
            if (expQ.size() == 0) begin
                check(destWrite, 0);
            end else begin
                note = expQ.pop_front();
                check({cfgType, destValue}, note);
                check({cfgType, lenCsr}, note);
                check(destIndex, 1);
            end
        end
    end
    // Main sequence: every code, then random back-to-back words.
    initial begin
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk) rst = 0;
        check({cfgType, lenCsr}, 64'h8000_0000_0000_0000);
        for (int t = 0; t < 256; t++) begin
            word = {4'h0, t[7:0], 5'h0, 3'h7, 5'h1, 7'h57};
            issue(word, 0, 0, expectOf(t, '1));
        end
        repeat (200) begin
            rnd = nextRnd(rnd);
            ty = rnd & (rnd[12] ? 32'h8000_01FF : 32'h0000_00FF);
            req = {24'h0, rnd[20:13]};
            word = {7'h40, 5'h3, 5'h2, 3'h7, 5'h1, 7'h57};
            issue(word, req, ty, expectOf(ty, req));
            word = {2'h3, ty[9:0], req[4:0], 3'h7, 5'h1, 7'h57};
            issue(word, 0, 0, expectOf(ty[9:0], req[4:0]));
        end
        // Same maximum length: the type changes and the length stays.
        word = {4'h0, 8'h00, 5'h0, 3'h7, 5'h1, 7'h57};
        issue(word, 0, 0, {32'h0, 32'h10});
        word = {4'h0, 8'h09, 5'h0, 3'h7, 5'h0, 7'h57};
        issue(word, 0, 0, 0);
        @(posedge sys_clk);
        check(accepted, 1);
        issue(32'h0000_0013, 0, 0, 0);
        @(posedge sys_clk);
        check(accepted, 0);
        @(negedge sys_clk) issueValid = 0;
        repeat (2) @(negedge sys_clk);
        check({cfgType, lenCsr}, {32'h9, 32'h10});
        // A changed maximum length in the both-zero form is refused.
        word = {4'h0, 8'h08, 5'h0, 3'h7, 5'h0, 7'h57};
        issue(word, 0, 0, 0);
        @(negedge sys_clk) issueValid = 0;
        @(negedge sys_clk);
        check({cfgType, lenCsr}, 64'h8000_0000_0000_0000);
        repeat (2) @(negedge sys_clk);
        check(expQ.size(), 0);
        giveVerdict();
    end
    // Watchdog against a hang.
    initial begin
        #20000;
        errorCnt++;
        giveVerdict();
    end
endmodule // tb
`default_nettype wire

/* File: vlc_cfg.svh */
// Constants for the vector length configuration block.
`ifndef VLC_CFG_SVH
`define VLC_CFG_SVH

// ----------------------------------------------------------------------------
// Instruction encoding
// ----------------------------------------------------------------------------
`define VLC_OPCODE 7'h57
`define VLC_FUNCT3 3'h7

// ----------------------------------------------------------------------------
// Type register field positions
// ----------------------------------------------------------------------------
`define VLC_MA_BIT 7
`define VLC_TA_BIT 6
`define VLC_EW_HI 5
`define VLC_EW_LO 3
`define VLC_GM_HI 2
`define VLC_GM_LO 0
`define VLC_RSV_LO 8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define VLC_LEN_RESET 0

`endif

/* File: vlc_config.sv */
// Vector configuration instruction executor.
// How it works
// - Each instruction updates type and length, writes granted length to a nonzero dest.
// - Immediate forms carry 11-bit or 10-bit type; register form uses src2.
// - Type: illegal flag at top, reserved above 7, agnostic bits, widths.
// - Type comes from immediate, or from src2 register for register form.
// - Unsupported type sets illegal flag, clears other bits, length zero.
// - A requested type with illegal flag set counts as unsupported.
// - Every type bit except agnostic bits 7:6 is checked, reserved ones included.
// - Nonzero src1: requested length is that register's value.
// - Zero src1, nonzero dest: requested length is all ones.
// - Both zero: current length is requested, no scalar write.
// - Both-zero form changing max length or from illegal may set flag.
// - Both-immediate form uses 5-bit zero-extended length immediate.
// - Grant request if it fits, else the maximum length.
// - Grant is deterministic in requested and maximum length.
// - Mask-agnostic bit is exported for the element datapath.
// - Tail-agnostic bit is exported for the element datapath.
`include "vlc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module vlc_config
    import vlc_pkg::*;
#(
    parameter int XW = 32,
    parameter int VREG_BITS = 128,
    parameter int MAX_EW = 64
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Instruction issue.
    input wire logic issueValid,
    input wire logic [31:0] instr,
    input wire logic [XW-1:0] src1Value,
    input wire logic [XW-1:0] src2Value,
    // Scalar write-back.
    output logic destWrite,
    output logic [4:0] destIndex,
    output logic [XW-1:0] destValue,
    // Architectural state, and acceptance of the issued word.
    output logic [XW-1:0] vector_config_type,
    output logic [XW-1:0] vector_length_csr,
    output logic maskAgnostic,
    output logic tailAgnostic,
    output logic accepted
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [XW-1:0] cfgType;
        logic [XW-1:0] lenCsr;
        logic wb;
        logic [4:0] wbIdx;
        logic [XW-1:0] wbVal;
    } vlc_state_s;

    vlc_state_s st;
    vlc_state_s next_st;
    vlc_form_e form;
    logic [XW-1:0] newType;
    logic [XW-1:0] reqLen;
    logic [XW-1:0] maxLen;
    logic [XW-1:0] curMax;
    logic [XW-1:0] grant;
    logic supported;
    logic bothZero;
    logic [4:0] rs1Idx;
    logic [4:0] rdIdx;

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------

    // Decode the instruction form from the major opcode and top bits.
    always_comb begin
        form = VLC_NONE;
        if (issueValid && instr[6:0] == `VLC_OPCODE &&
            instr[14:12] == `VLC_FUNCT3) begin
            if (!instr[31]) begin
                form = VLC_IMM_TYPE;
            end else if (instr[30]) begin
                form = VLC_IMM_BOTH;
            end else if (instr[29:25] == 5'h0_0) begin
                form = VLC_REG_TYPE;
            end
        end
    end

    assign rs1Idx = instr[19:15];
    assign rdIdx = instr[11:7];
    assign bothZero = (rs1Idx == 5'h0_0) && (rdIdx == 5'h0_0);

    // ------------------------------------------------------------------------
    // Type selection and support check
    // ------------------------------------------------------------------------

    // Select the new type value from the immediate or src2 register.
    always_comb begin
        unique case (form)
            VLC_IMM_TYPE: newType = XW'(instr[30:20]);
            VLC_IMM_BOTH: newType = XW'(instr[29:20]);
            VLC_REG_TYPE: newType = src2Value;
            default: newType = '0;
        endcase
    end

    // Max length from a type: register bits times multiplier over width.
    function automatic logic [XW-1:0] maxFor(input logic [XW-1:0] t);
        int ew;
        int m;
        ew = 8 << t[`VLC_EW_HI:`VLC_EW_LO];
        m = VREG_BITS / ew;
        // Fractional codes shift right, so tiny ratios can fall to zero.
        if (t[`VLC_GM_HI]) begin
            m = m >> (4 - int'(t[1:0]));
        end else begin
            m = m << t[1:0];
        end
        return XW'(m);
    endfunction

    // Check all bits of the requested type except the agnostic bits for support.
    always_comb begin
        supported = 1'b1;
        if (newType[XW-1]) supported = 1'b0;
        if (|newType[XW-2:`VLC_RSV_LO]) supported = 1'b0;
        if (newType[`VLC_EW_HI]) supported = 1'b0;
        if ((8 << newType[4:3]) > MAX_EW) supported = 1'b0;
        if (newType[2:0] == 3'h4) supported = 1'b0;
        maxLen = maxFor(newType);
        curMax = maxFor(st.cfgType);
        // A maximum length of zero could hold no element, so refuse it.
        if (maxLen == '0) supported = 1'b0;
        // Both-zero form that would change max length or follow illegal.
        if (form != VLC_IMM_BOTH && bothZero &&
            (st.cfgType[XW-1] || curMax != maxLen)) begin
            supported = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Requested and granted length
    // ------------------------------------------------------------------------

    // Pick the requested length from the operand encoding.
    always_comb begin
        if (form == VLC_IMM_BOTH) begin
            reqLen = XW'(rs1Idx);
        end else if (rs1Idx != 5'h0_0) begin
            reqLen = src1Value;
        end else if (rdIdx != 5'h0_0) begin
            reqLen = '1;
        end else begin
            reqLen = st.lenCsr;
        end
    end

    vlc_grant #(
        .XW(XW)
    ) u_grant (
        .requestedLength(reqLen),
        .maxLength(maxLen),
        .grantedLength(grant)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------

    // Compute the next architectural state.
    always_comb begin
        next_st = st;
        next_st.wb = 1'b0;
        if (form != VLC_NONE) begin
            if (supported) begin
                next_st.cfgType = newType;
                next_st.lenCsr = grant;
            end else begin
                next_st.cfgType = '0;
                next_st.cfgType[XW-1] = 1'b1;
                next_st.lenCsr = '0;
            end
            // A zero destination gets no write-back pulse at all.
            next_st.wb = (rdIdx != 5'h0_0);
            next_st.wbIdx = rdIdx;
            next_st.wbVal = supported ? grant : '0;
        end
    end

    // ------------------------------------------------------------------------
    // Registers and outputs
    // ------------------------------------------------------------------------

    // Register the state.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st.cfgType <= {1'b1, {(XW-1){1'b0}}};
            st.lenCsr <= XW'(`VLC_LEN_RESET);
            st.wb <= 1'b0;
            st.wbIdx <= 5'h0_0;
            st.wbVal <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs.
    assign destWrite = st.wb;
    assign destIndex = st.wbIdx;
    assign destValue = st.wbVal;
    assign vector_config_type = st.cfgType;
    assign vector_length_csr = st.lenCsr;
    assign maskAgnostic = st.cfgType[`VLC_MA_BIT];
    assign tailAgnostic = st.cfgType[`VLC_TA_BIT];
    assign accepted = (form != VLC_NONE);

endmodule // vlc_config
`default_nettype wire

/* File: vlc_config_monitor.sv */
// Assertion checker for the vector length configuration block.
`timescale 1ns/1ns
`default_nettype none
module vlc_config_monitor
    import vlc_pkg::*;
#(
    parameter int XW = 32
) (
    // Clock, reset and issue.
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic issueValid,
    input wire logic [31:0] instr,
    // Results.
    input wire logic destWrite,
    input wire logic [4:0] destIndex,
    input wire logic [XW-1:0] destValue,
    input wire logic [XW-1:0] vector_config_type,
    input wire logic [XW-1:0] vector_length_csr,
    input wire logic maskAgnostic,
    input wire logic tailAgnostic,
    input wire logic accepted
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // A configuration word taken at this edge, and one naming a destination.
    sequence taken;
        issueValid && accepted;
    endsequence
    sequence takenRd;
        taken ##0 instr[11:7] != 5'h0;
    endsequence
    // A word of either immediate form, whose agnostic bits sit at 27:26.
    sequence takenImm;
        taken ##0 (!instr[31] || instr[30]);
    endsequence
    chk_dest_pulse: assert property (takenRd |=> destWrite
        && destIndex == $past(instr[11:7])) else $error("write-back lost");
    chk_no_write: assert property (!(issueValid && accepted &&
        instr[11:7] != 5'h0) |=> !destWrite) else $error("stray write-back");
    chk_dest_len: assert property (destWrite |->
        destValue == vector_length_csr) else $error("dest differs from len");
    chk_ill_clear: assert property (vector_config_type[XW-1] |->
        vector_config_type[XW-2:0] == '0 && vector_length_csr == '0)
        else $error("illegal type not cleared");
    chk_idle_hold: assert property (!(issueValid && accepted) |=>
        $stable(vector_config_type) && $stable(vector_length_csr))
        else $error("state changed when idle");
    chk_imm_len: assert property (taken ##0 instr[31:30] == 2'h3 |=>
        vector_length_csr <= $past(instr[19:15])) else $error("imm length");
    chk_agn_bits: assert property (takenImm |=>
        vector_config_type[XW-1] || {maskAgnostic, tailAgnostic} ==
        $past(instr[27:26])) else $error("agnostic bits");
    chk_max_req: assert property (takenRd ##0 instr[19:15] == 5'h0
        ##0 instr[31:30] != 2'h3 |=> vector_length_csr != '0 ||
        vector_config_type[XW-1]) else $error("all-ones request gave zero");
endmodule // vlc_config_monitor
bind vlc_config vlc_config_monitor #(.XW(XW)) mon_u (.sys_clk, .rst,
    .issueValid, .instr, .destWrite, .destIndex, .destValue,
    .vector_config_type, .vector_length_csr, .maskAgnostic, .tailAgnostic,
    .accepted);
`default_nettype wire

/* File: vlc_grant.sv */
// Granted length from requested length and maximum length.
`timescale 1ns/1ns
`default_nettype none
module vlc_grant
    import vlc_pkg::*;
#(
    parameter int XW = 32
) (
    // Operands.
    input wire logic [XW-1:0] requestedLength,
    input wire logic [XW-1:0] maxLength,
    // Result.
    output logic [XW-1:0] grantedLength
);

    // Grant the request when it fits, else the maximum; deterministic.
    always_comb begin
        if (requestedLength <= maxLength) begin
            grantedLength = requestedLength;
        end else begin
            grantedLength = maxLength;
        end
    end

endmodule // vlc_grant
`default_nettype wire

/* File: vlc_pkg.sv */
// Types shared by the vector length configuration block.
package vlc_pkg;

    // Decoded configuration instruction form.
    typedef enum logic [1:0] {
        VLC_NONE,
        VLC_IMM_TYPE,
        VLC_IMM_BOTH,
        VLC_REG_TYPE
    } vlc_form_e;

endpackage

/* File: vlc_scalar_pipe.sv */
// Scalar register file model standing for the issuing pipeline.
`timescale 1ns/1ns
`default_nettype none
module vlc_scalar_pipe
    import vlc_pkg::*;
(
    // Clock, issued word and write-back.
    input wire logic sys_clk,
    input wire logic [31:0] instr,
    input wire logic destWrite,
    input wire logic [4:0] destIndex,
    input wire logic [31:0] destValue,
    // Operands for the issued word.
    output logic [31:0] src1Value,
    output logic [31:0] src2Value
);
    logic [31:0] regs [32];
    // Register zero reads as zero; the others read straight from the file.
    assign src1Value = (instr[19:15] == 5'h0) ? 32'h0 : regs[instr[19:15]];
    assign src2Value = (instr[24:20] == 5'h0) ? 32'h0 : regs[instr[24:20]];
    // Write-back lands at the clock edge.
    always @(posedge sys_clk) begin
        if (destWrite && destIndex != 5'h0) begin
            regs[destIndex] <= destValue;
        end
    end
endmodule // vlc_scalar_pipe
`default_nettype wire
